// file: rtl/sfph_handler.sv
`timescale 1ns/1ps
// Notes on behaviour
// - pump undervoltage: immediate hi-z, unlatched, fault pin
// - every hi-z also applies weak pulldowns
// - logic ov/oc, buck oc: report only
// - logic undervoltage tops both arbitration sections
// - logic undervoltage forces hi-z with pulldowns
// - logic undervoltage halts until chip-enable toggles
// - buck keeps regulating during logic undervoltage halt
// - logic undervoltage moves running state to stop
// - buck overcurrent ignored during pump start
// - supply faults by fixed priority, B0 highest
// - first other fault held; ties by priority
// - both sections ORed onto fault pin
module sfph_handler
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic chip_enable_pin,
  input wire logic start_request,
  input wire logic pump_starting,
  input wire sfph_pkg::sfph_det_t det_async,
  input wire logic fault_clear_field,
  output logic fault_out_pin_o,
  output logic fault_out_pin_oe,
  output logic gate_hiz,
  output logic gate_pulldown,
  output logic buck_enable,
  output logic [2:0] state_code,
  output logic [2:0] sup_active_slot,
  output logic [2:0] oth_active_slot,
  output sfph_pkg::sfph_stat_t status
);
  import sfph_pkg::*;

  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  sfph_det_t det_s1_reg;
  sfph_det_t det_reg;
  logic ce_s1_reg;
  logic ce_reg;
  logic ce_prev_reg;

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      det_s1_reg <= '0;
      det_reg <= '0;
      ce_s1_reg <= 1'b0;
      ce_reg <= 1'b0;
      ce_prev_reg <= 1'b0;
    end
    else if (clk_en)
    begin
      det_s1_reg <= det_async;
      det_reg <= det_s1_reg;
      ce_s1_reg <= chip_enable_pin;
      ce_reg <= ce_s1_reg;
      ce_prev_reg <= ce_reg;
    end
  end

  wire ce_rise = ce_reg & ~ce_prev_reg;
  wire ce_low = ~ce_reg;

  // ----------------------------------------
  // functional state
  // ----------------------------------------
  sfph_state_t state_reg;
  sfph_state_t state_next;
  wire running = (state_reg == ST_RUN);
  wire pump_uv = det_reg.pump_low_uv | det_reg.pump_high_uv;
  // blanking hides buck overcurrent while the pumps charge up
  wire buck_oc_seen = det_reg.buck_oc & ~pump_starting;

  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE:
        if (ce_reg & start_request)
          state_next = ST_RUN;
      ST_RUN:
        if (det_reg.logic_uv)
          state_next = ST_STOP;
        else if (ce_low)
          state_next = ST_IDLE;
      // only a fresh chip-enable rise leaves the stop state;
      // clearing faults has no effect here
      ST_STOP:
        if (ce_rise)
          state_next = ST_IDLE;
      default:
        state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      state_reg <= ST_IDLE;
    else if (clk_en)
      state_reg <= state_next;
  end

  // ----------------------------------------
  // supply section: fixed priority
  // ----------------------------------------
  logic [SUP_SLOTS-1:0] sup_req;
  assign sup_req[SUP_B0] = det_reg.logic_uv;
  assign sup_req[SUP_B1] = det_reg.logic_ov;
  assign sup_req[SUP_B2] = buck_oc_seen;
  assign sup_req[SUP_B3] = det_reg.logic_oc;
  assign sup_req[SUP_B4] = 1'b0;

  logic [2:0] sup_win;
  always_comb
  begin
    sup_win = OTH_NONE;
    for (int i = SUP_SLOTS - 1; i >= 0; i--)
      if (sup_req[i])
        sup_win = 3'(i);
  end

  // ----------------------------------------
  // other section: first come, ties by priority
  // ----------------------------------------
  logic [OTH_SLOTS-1:0] oth_req;
  assign oth_req[OTH_F0] = det_reg.logic_uv;
  assign oth_req[OTH_F1] = pump_uv & running;
  assign oth_req[OTH_F2] = pump_uv & running;

  logic [2:0] oth_pick;
  always_comb
  begin
    oth_pick = OTH_NONE;
    for (int i = OTH_SLOTS - 1; i >= 0; i--)
      if (oth_req[i])
        oth_pick = 3'(i);
  end

  logic [2:0] oth_reg;
  logic [2:0] oth_next;
  wire oth_busy = (oth_reg != OTH_NONE);
  // held fault drops once its condition is gone (unlatched)
  wire oth_gone = oth_busy & ~oth_req[oth_reg[1:0]];
  assign oth_next = (!oth_busy || oth_gone) ? oth_pick : oth_reg;

  always_ff @(posedge sys_clk)
  begin
    if (rst)
      oth_reg <= OTH_NONE;
    else if (clk_en)
      oth_reg <= oth_next;
  end

  // ----------------------------------------
  // reactions and outputs
  // ----------------------------------------
  // pump hi-z acts straight from the detector, bypassing arbitration
  wire hiz_now = (pump_uv & running) | det_reg.logic_uv
                 | (state_reg == ST_STOP);
  wire sup_flag = (sup_win != OTH_NONE);
  wire fault_any = sup_flag | oth_busy | (pump_uv & running)
                   | (state_reg == ST_STOP);

  logic fault_reg;
  logic hiz_reg;
  sfph_stat_t stat_reg;
  sfph_stat_t stat_next;
  sfph_stat_t stat_now;

  assign stat_now = '{pump_low_uv: det_reg.pump_low_uv,
                      pump_high_uv: det_reg.pump_high_uv,
                      logic_ov: det_reg.logic_ov,
                      logic_oc: det_reg.logic_oc,
                      logic_uv: det_reg.logic_uv,
                      buck_oc: buck_oc_seen};
  // new events win over a clear in the same cycle
  assign stat_next = stat_now | (fault_clear_field ? '0 : stat_reg);

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      fault_reg <= 1'b0;
      hiz_reg <= 1'b1;
      stat_reg <= '0;
    end
    else if (clk_en)
    begin
      fault_reg <= fault_any;
      hiz_reg <= hiz_now | (state_reg != ST_RUN);
      stat_reg <= stat_next;
    end
  end

  // fault pin is open drain, active low: drive low when faulted
  assign fault_out_pin_o = 1'b0;
  assign fault_out_pin_oe = fault_reg;
  assign gate_hiz = hiz_reg;
  assign gate_pulldown = hiz_reg;
  assign buck_enable = 1'b1;
  assign state_code = state_reg;
  assign sup_active_slot = sup_win;
  assign oth_active_slot = oth_reg;
  assign status = stat_reg;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  AST_PUMP_HIZ: assert property (@(posedge sys_clk) disable iff (rst)
    clk_en && running && pump_uv |=> gate_hiz && fault_out_pin_oe)
    else $error("pump undervoltage did not force hi-z and fault");
  AST_PULLDOWN: assert property (@(posedge sys_clk) disable iff (rst)
    gate_hiz == gate_pulldown)
    else $error("hi-z without pulldown");
  AST_REPORT_ONLY: assert property (@(posedge sys_clk)
    disable iff (rst)
    clk_en && running && !pump_uv && !det_reg.logic_uv && !ce_low
      && sup_win == 3'(SUP_B1) |=> !gate_hiz && fault_out_pin_oe)
    else $error("report-only fault changed the driver");
  AST_UV_TOP: assert property (@(posedge sys_clk) disable iff (rst)
    det_reg.logic_uv |-> sup_win == 3'(SUP_B0))
    else $error("logic undervoltage not top priority");
  AST_UV_STOP: assert property (@(posedge sys_clk) disable iff (rst)
    clk_en && running && det_reg.logic_uv |=> state_reg == ST_STOP)
    else $error("logic undervoltage did not stop device");
  AST_HALT: assert property (@(posedge sys_clk) disable iff (rst)
    clk_en && state_reg == ST_STOP && !ce_rise
      |=> state_reg == ST_STOP)
    else $error("halt left without chip-enable toggle");
  AST_HALT_HIZ: assert property (@(posedge sys_clk) disable iff (rst)
    state_reg == ST_STOP && $past(state_reg) == ST_STOP |-> gate_hiz)
    else $error("halt without hi-z");
  AST_BLANK: assert property (@(posedge sys_clk) disable iff (rst)
    pump_starting |-> !stat_now.buck_oc)
    else $error("buck overcurrent not blanked");
  AST_RELEASE: assert property (@(posedge sys_clk) disable iff (rst)
    clk_en && oth_busy && !oth_req[oth_reg[1:0]]
      && oth_pick == OTH_NONE |=> !oth_busy)
    else $error("unlatched fault not withdrawn");
endmodule

// file: rtl/sfph_pkg.sv
package sfph_pkg;
  // supply arbitration slots, index equals priority (0 highest)
  localparam int SUP_SLOTS = 5;
  localparam int SUP_B0 = 0;
  localparam int SUP_B1 = 1;
  localparam int SUP_B2 = 2;
  localparam int SUP_B3 = 3;
  localparam int SUP_B4 = 4;
  // other-fault slots handled here (F1 and F2 have own slots but share one request)
  localparam int OTH_SLOTS = 3;
  localparam int OTH_F0 = 0;
  localparam int OTH_F1 = 1;
  localparam int OTH_F2 = 2;
  localparam logic [2:0] OTH_NONE = 3'h7;

  typedef struct packed {
    logic pump_low_uv;
    logic pump_high_uv;
    logic logic_ov;
    logic logic_oc;
    logic logic_uv;
    logic buck_oc;
  } sfph_det_t;

  typedef struct packed {
    logic pump_low_uv;
    logic pump_high_uv;
    logic logic_ov;
    logic logic_oc;
    logic logic_uv;
    logic buck_oc;
  } sfph_stat_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_RUN = 3'b010,
    ST_STOP = 3'b100
  } sfph_state_t;
endpackage

// file: testbench/sfph_host_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// host side: pulled-up pin, clear strobe
// ----------------------------------------
module sfph_host_model
(
  input wire logic sys_clk,
  input wire logic fault_out_pin_oe,
  input wire logic clear_req,
  output logic fault_pin_level,
  output logic fault_clear_field
);
  // pull-up on the board, so a released pin reads high
  assign fault_pin_level = !fault_out_pin_oe;
  always @(posedge sys_clk)
  begin
    fault_clear_field <= clear_req;
  end
endmodule

// file: testbench/sfph_handler_tb_top.sv
`timescale 1ns/1ps
module sfph_handler_tb_top;
  import sfph_pkg::*;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b0;
  logic start = 1'b0;
  logic pump = 1'b0;
  logic clr = 1'b0;
  logic en = 1'b1;
  sfph_det_t det = '0;
  sfph_det_t d;
  logic o, oe, hiz, pd, buck, pin, fcf;
  logic [2:0] st, sup, oth;
  sfph_stat_t stat;
  int miscompares = 0;
  int checks = 0;
  always #2 sys_clk = ~sys_clk;
  sfph_handler uut (.sys_clk(sys_clk), .rst(rst), .clk_en(en),
    .chip_enable_pin(ce), .start_request(start), .pump_starting(pump),
    .det_async(det), .fault_clear_field(fcf), .fault_out_pin_o(o),
    .fault_out_pin_oe(oe), .gate_hiz(hiz), .gate_pulldown(pd),
    .buck_enable(buck), .state_code(st), .sup_active_slot(sup),
    .oth_active_slot(oth), .status(stat));
  sfph_host_model host (.sys_clk(sys_clk), .fault_out_pin_oe(oe),
    .clear_req(clr), .fault_pin_level(pin), .fault_clear_field(fcf));
  task automatic give_verdict;
    if (miscompares == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // detector levels pass two sync flops, then two more edges
  task automatic apply(input sfph_det_t v);
    @(posedge sys_clk);
    det <= v;
    repeat (4) @(posedge sys_clk);
    #1;
  endtask
  task automatic clear_pulse;
    @(posedge sys_clk);
    clr <= 1'b1;
    @(posedge sys_clk);
    clr <= 1'b0;
    repeat (3) @(posedge sys_clk);
    #1;
  endtask
  task automatic t_run;
    @(posedge sys_clk);
    ce <= 1'b1;
    start <= 1'b1;
    for (int i = 0; i < 20 && st !== ST_RUN; i++)
    begin
      @(posedge sys_clk);
      #1;
    end
    // gate hi-z follows the state by one more edge
    @(posedge sys_clk);
    #1;
    if (st !== ST_RUN)
    begin
      miscompares++;
      give_verdict();
    end
    check(hiz, 8'h0);
  endtask
  task automatic t_pump;
    for (int k = 0; k < 2; k++)
    begin
      d = '0;
      d.pump_low_uv = (k == 0);
      d.pump_high_uv = (k == 1);
      apply(d);
      check({hiz, oe, o, pin}, 8'hc);
      check(pd, 8'h1);
      check(oth, 8'h1);
      apply('0);
      check({hiz, oe, pin}, 8'h1);
      check(st, ST_RUN);
    end
  endtask
  task automatic t_report;
    logic [2:0] slot [3] = '{3'h1, 3'h2, 3'h3};
    for (int k = 0; k < 3; k++)
    begin
      d = '0;
      d.logic_ov = (k == 0);
      d.buck_oc = (k == 1);
      d.logic_oc = (k == 2);
      apply(d);
      check(sup, slot[k]);
      check({oe, hiz, pin}, 8'h4);
      check(st, ST_RUN);
      apply('0);
      check(oe, 8'h0);
    end
    d = '0;
    d.logic_ov = 1'b1;
    d.logic_oc = 1'b1;
    apply(d);
    check(sup, 8'h1);
    apply('0);
    check(stat, 8'h3d);
    clear_pulse();
    check(stat, 8'h0);
    @(posedge sys_clk);
    pump <= 1'b1;
    d = '0;
    d.buck_oc = 1'b1;
    apply(d);
    check({oe, stat}, 8'h0);
    apply('0);
    @(posedge sys_clk);
    pump <= 1'b0;
  endtask
  // a low clock enable must hold every flop, synchronisers included
  task automatic t_freeze;
    @(posedge sys_clk);
    en <= 1'b0;
    d = '0;
    d.logic_ov = 1'b1;
    apply(d);
    check({st, oe, sup, stat}, 16'h09c0);
    apply('0);
    @(posedge sys_clk);
    en <= 1'b1;
    repeat (4) @(posedge sys_clk);
    #1;
    check({st, oe, sup, stat}, 16'h09c0);
  endtask
  task automatic t_uv;
    d = '0;
    d.logic_uv = 1'b1;
    d.pump_low_uv = 1'b1;
    apply(d);
    check(st, ST_STOP);
    check({hiz, pd, oe}, 8'h7);
    check({sup, oth}, 8'h0);
    check(buck, 8'h1);
    apply('0);
    clear_pulse();
    check({st, hiz}, {ST_STOP, 1'b1});
    check(buck, 8'h1);
    @(posedge sys_clk);
    ce <= 1'b0;
    start <= 1'b0;
    repeat (4) @(posedge sys_clk);
    #1;
    check(st, ST_STOP);
    @(posedge sys_clk);
    ce <= 1'b1;
    repeat (5) @(posedge sys_clk);
    #1;
    check(st, ST_IDLE);
  endtask
  initial
  begin
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    #1;
    check({st, hiz, pd, oe}, {ST_IDLE, 3'b110});
    check({stat, oth}, 8'h7);
    t_run();
    t_pump();
    t_report();
    t_freeze();
    t_uv();
    give_verdict();
  end
endmodule
